/* hw/cpr_ctrl.sv */
// Clock source, divider, power mode and reset sequencer of the microcontroller
`timescale 1ns/1ps
`include "cpr_map.svh"

module cpr_ctrl #(
    parameter int WARMUP_CYCLES = `CPR_WARMUP_OSC
) (
    // Clock and power-on reset
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    // Register port
    input  wire logic [3:0]            reg_addr,
    input  wire logic [15:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [15:0]                reg_rdata,
    // Oscillator ticks, one bit per source, indexed by source code
    input  wire logic [4:0]            osc_tick,
    output logic                       hf_osc_enable,
    // Wake and reset causes
    input  wire logic                  ext_int_wake,
    input  wire logic                  rtc_alarm_wake,
    input  wire logic                  switchback_irq,
    input  wire logic                  watchdog_reset_req,
    // Bidirectional reset pin
    input  wire logic                  reset_pin_in,
    output logic                       reset_pin_out,
    output logic                       reset_pin_oe_n,
    // CPU side
    output logic                       sys_clk_en,
    output logic                       cpu_reset,
    output logic [15:0]                cpu_start_addr,
    output cpr_pkg::cpr_src_e          active_source,
    output logic                       irq
);
    import cpr_pkg::*;

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    // Warm-up count must fit the 20-bit counter
    if (WARMUP_CYCLES < 1 || WARMUP_CYCLES >= (1 << 20)) begin : g_bad_warmup
        $error("WARMUP_CYCLES out of range");
    end
    // Pin hold must fit the 5-bit hold counter
    if (`CPR_RST_HOLD_CYC < 1 || `CPR_RST_HOLD_CYC > 32) begin : g_bad_hold
        $error("reset hold count out of range");
    end

    // ----------------------------------------------------------------
    // Derived constants
    // ----------------------------------------------------------------
    // Hold covers the pin drive after power-on and watchdog resets
    localparam logic [19:0] WARM_LAST = 20'(WARMUP_CYCLES - 1);
    localparam logic [4:0]  HOLD_LAST = 5'(`CPR_RST_HOLD_CYC - 1);

    // ----------------------------------------------------------------
    // State and decode signals
    // ----------------------------------------------------------------
    cpr_state_s r;
    cpr_state_s next_r;

    logic       pin_ext_low;
    logic       osc_now;
    logic       sys_tick;
    logic [7:0] tick_last;
    logic       mode_256;
    logic       mode_32k;
    cpr_src_e   want_src;
    logic [2:0] irq_set;
    logic [2:0] irq_clr;

    // ----------------------------------------------------------------
    // Clock selection and division
    // ----------------------------------------------------------------
    always_comb begin
        // Pin reads low only from outside while we are not pulling it
        pin_ext_low = !reset_pin_in && !r.pin_drive;
        mode_256    = r.pm_en && (r.div_sel == `CPR_DIV_1);
        mode_32k    = r.pm_en && (r.div_sel == `CPR_DIV_SLOW);
        if (mode_32k) begin
            want_src = (r.src_sel == CPR_SRC_LF_EXT) ? CPR_SRC_LF_EXT : CPR_SRC_LF_XTAL;
        end else if (r.src_sel == CPR_SRC_HF_XTAL && !r.xtal_ready) begin
            want_src = CPR_SRC_RING;
        end else if (r.src_sel > CPR_SRC_LF_EXT) begin
            // Unused source codes fall back to the ring
            want_src = CPR_SRC_RING;
        end else begin
            want_src = r.src_sel;
        end
        osc_now   = osc_tick[r.act_src];
        // Divide-by-256 overrides the two-bit ratio
        tick_last = r.act_d256 ? `CPR_D256_LAST : 8'((1 << r.act_div) - 1);
        sys_tick  = osc_now && (r.tick_cnt == tick_last);
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r            = r;
        next_r.rdata      = 16'h0000;
        next_r.sys_clk_en = 1'b0;
        irq_set           = 3'h0;
        irq_clr           = 3'h0;

        // ------------------------------------------------------------
        // Crystal warm-up
        // ------------------------------------------------------------
        // Counts crystal cycles while its oscillator is on, until the crystal is ready
        if (r.hf_osc_en && !r.xtal_ready && osc_tick[CPR_SRC_HF_XTAL]) begin
            if (r.warm_cnt == WARM_LAST) begin
                next_r.xtal_ready = 1'b1;
                irq_set[`CPR_IRQ_WARM_DONE] = 1'b1;
            end else begin
                next_r.warm_cnt = r.warm_cnt + 20'h00001;
            end
        end

        // ------------------------------------------------------------
        // System clock divider
        // ------------------------------------------------------------
        // Divider only runs while code may execute
        if (r.state == CPR_ST_RUN) begin
            if (osc_now) begin
                next_r.tick_cnt = sys_tick ? 8'h00 : r.tick_cnt + 8'h01;
            end
            if (sys_tick) begin
                next_r.sys_clk_en = 1'b1;
                next_r.act_src    = want_src;
                next_r.act_div    = r.div_sel;
                next_r.act_d256   = mode_256;
            end
        end

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (reg_wr) begin
            unique case (reg_addr)
                `CPR_ADDR_CTRL: begin
                    next_r.div_sel   = reg_wdata[`CPR_CTRL_DIV_HI:`CPR_CTRL_DIV_LO];
                    next_r.pm_en     = reg_wdata[`CPR_CTRL_PM_EN];
                    next_r.stop_req  = reg_wdata[`CPR_CTRL_STOP];
                    next_r.sb_en     = reg_wdata[`CPR_CTRL_SB_EN];
                    next_r.wait_warm = reg_wdata[`CPR_CTRL_WAIT_WARM];
                    next_r.src_sel   = cpr_src_e'(reg_wdata[`CPR_CTRL_SRC_HI:`CPR_CTRL_SRC_LO]);
                end
                `CPR_ADDR_WDCTRL: begin
                    if (!reg_wdata[`CPR_WD_POR_BIT]) begin
                        next_r.por_flag = 1'b0;
                    end
                end
                `CPR_ADDR_IRQ_STAT: irq_clr = reg_wdata[`CPR_IRQ_W-1:0];
                `CPR_ADDR_IRQ_MASK: next_r.irq_mask = reg_wdata[`CPR_IRQ_W-1:0];
                default: ;
            endcase
        end

        // ------------------------------------------------------------
        // Switchback
        // ------------------------------------------------------------
        // Leaves power mode; the clock returns to the selected source and two-bit divider ratio
        if (r.state == CPR_ST_RUN && r.sb_en && r.pm_en && switchback_irq) begin
            next_r.pm_en = 1'b0;
            irq_set[`CPR_IRQ_SWITCHBACK] = 1'b1;
        end

        // ------------------------------------------------------------
        // Reset and power sequence
        // ------------------------------------------------------------
        unique case (r.state)
            CPR_ST_POR, CPR_ST_WDT: begin
                next_r.pin_drive = 1'b1;
                next_r.hold_cnt  = r.hold_cnt + 5'h01;
                if (r.hold_cnt == HOLD_LAST) begin
                    next_r.state     = CPR_ST_EXT;
                    next_r.pin_drive = 1'b0;
                end
            end
            CPR_ST_EXT: begin
                // Pin released: restart at the fixed entry point
                if (reset_pin_in && !r.pin_drive) begin
                    next_r.state     = CPR_ST_RUN;
                    next_r.cpu_reset = 1'b0;
                end
            end
            CPR_ST_RUN: begin
                // Written value is used so a stop write halts at once
                if (next_r.stop_req) begin
                    next_r.state      = CPR_ST_STOP;
                    next_r.hf_osc_en  = 1'b0;
                    next_r.xtal_ready = 1'b0;
                    next_r.warm_cnt   = 20'h00000;
                    next_r.sys_clk_en = 1'b0;
                    next_r.tick_cnt   = 8'h00;
                end
            end
            CPR_ST_STOP: begin
                if (ext_int_wake || rtc_alarm_wake) begin
                    next_r.stop_req  = 1'b0;
                    next_r.hf_osc_en = 1'b1;
                    irq_set[`CPR_IRQ_STOP_EXIT] = 1'b1;
                    // Waiting only makes sense when the crystal is the chosen source
                    if (r.wait_warm && r.src_sel == CPR_SRC_HF_XTAL) begin
                        next_r.state = CPR_ST_WARM_WAIT;
                    end else begin
                        next_r.state   = CPR_ST_RUN;
                        next_r.act_src = want_src;
                    end
                end
            end
            CPR_ST_WARM_WAIT: begin
                // No system pulses until the crystal has settled
                if (r.xtal_ready) begin
                    next_r.state   = CPR_ST_RUN;
                    next_r.act_src = CPR_SRC_HF_XTAL;
                end
            end
        endcase

        // ------------------------------------------------------------
        // Watchdog and external reset
        // ------------------------------------------------------------
        // Both take over from any state; a power-on hold is left alone
        if ((watchdog_reset_req || pin_ext_low) && r.state != CPR_ST_POR) begin
            if (watchdog_reset_req && r.state != CPR_ST_WDT) begin
                // A fresh watchdog request restarts the pin hold
                next_r.state    = CPR_ST_WDT;
                next_r.hold_cnt = 5'h00;
            end else if (pin_ext_low && r.state != CPR_ST_WDT) begin
                next_r.state = CPR_ST_EXT;
            end else begin
                // Stay in the running reset state while the cause persists
                next_r.state = r.state;
            end
            next_r.cpu_reset  = 1'b1;
            next_r.hf_osc_en  = 1'b1;
            next_r.pm_en      = 1'b0;
            next_r.stop_req   = 1'b0;
            next_r.div_sel    = `CPR_DIV_1;
            next_r.act_div    = `CPR_DIV_1;
            next_r.act_d256   = 1'b0;
            next_r.act_src    = CPR_SRC_RING;
            next_r.tick_cnt   = 8'h00;
            next_r.sys_clk_en = 1'b0;
        end
        if (r.state == CPR_ST_STOP && next_r.state == CPR_ST_EXT) begin
            irq_set[`CPR_IRQ_STOP_EXIT] = 1'b1;
        end

        // ------------------------------------------------------------
        // Interrupt status
        // ------------------------------------------------------------
        // Sticky events: a new event beats a clear in the same cycle
        next_r.irq_stat = (r.irq_stat & ~irq_clr) | irq_set;
        next_r.irq      = |(next_r.irq_stat & next_r.irq_mask);

        // ------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------
        // Answer in the next cycle only
        if (reg_rd) begin
            unique case (reg_addr)
                `CPR_ADDR_CTRL: begin
                    next_r.rdata[`CPR_CTRL_DIV_HI:`CPR_CTRL_DIV_LO] = r.div_sel;
                    next_r.rdata[`CPR_CTRL_PM_EN]     = r.pm_en;
                    next_r.rdata[`CPR_CTRL_STOP]      = r.stop_req;
                    next_r.rdata[`CPR_CTRL_SB_EN]     = r.sb_en;
                    next_r.rdata[`CPR_CTRL_WAIT_WARM] = r.wait_warm;
                    next_r.rdata[`CPR_CTRL_SRC_HI:`CPR_CTRL_SRC_LO] = r.src_sel;
                end
                `CPR_ADDR_STATUS: begin
                    next_r.rdata[2:0] = r.act_src;
                    next_r.rdata[3]   = r.xtal_ready;
                    next_r.rdata[4]   = (r.state == CPR_ST_STOP);
                    next_r.rdata[5]   = r.act_d256;
                    next_r.rdata[6]   = mode_32k;
                end
                `CPR_ADDR_WDCTRL:   next_r.rdata[`CPR_WD_POR_BIT] = r.por_flag;
                `CPR_ADDR_IRQ_STAT: next_r.rdata[`CPR_IRQ_W-1:0] = r.irq_stat;
                `CPR_ADDR_IRQ_MASK: next_r.rdata[`CPR_IRQ_W-1:0] = r.irq_mask;
                // Unmapped words read as zero
                default:            next_r.rdata = 16'h0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register; power-on reset clears it but sets the POR flag, CPU reset, oscillator enable and pin drive
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r            <= '0;
            r.state      <= CPR_ST_POR;
            r.src_sel    <= CPR_SRC_RING;
            r.act_src    <= CPR_SRC_RING;
            r.div_sel    <= `CPR_DIV_1;
            r.por_flag   <= 1'b1;
            r.cpu_reset  <= 1'b1;
            r.hf_osc_en  <= 1'b1;
            r.pin_drive  <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, straight from the state register except the constant pin level and start address
    // ----------------------------------------------------------------
    assign reg_rdata      = r.rdata;
    assign hf_osc_enable  = r.hf_osc_en;
    // Open-drain pin: only ever pulled low, never driven high
    assign reset_pin_out  = 1'b0;
    assign reset_pin_oe_n = !r.pin_drive;
    assign sys_clk_en     = r.sys_clk_en;
    assign cpu_reset      = r.cpu_reset;
    assign cpu_start_addr = `CPR_START_ADDR;
    assign active_source  = r.act_src;
    assign irq            = r.irq;

endmodule

/* hw/cpr_map.svh */
// Register offsets, field positions, reset values and timing counts of the clock controller
`ifndef CPR_MAP_SVH
`define CPR_MAP_SVH

// ----------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------
`define CPR_ADDR_CTRL       4'h0
`define CPR_ADDR_STATUS     4'h1
`define CPR_ADDR_WDCTRL     4'h2
`define CPR_ADDR_IRQ_STAT   4'h3
`define CPR_ADDR_IRQ_MASK   4'h4

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CPR_CTRL_DIV_LO     0
`define CPR_CTRL_DIV_HI     1
`define CPR_CTRL_PM_EN      2
`define CPR_CTRL_STOP       3
`define CPR_CTRL_SB_EN      4
`define CPR_CTRL_WAIT_WARM  5
`define CPR_CTRL_SRC_LO     6
`define CPR_CTRL_SRC_HI     8

// ----------------------------------------------------------------
// Watchdog control and interrupt fields
// ----------------------------------------------------------------
`define CPR_WD_POR_BIT      7
`define CPR_IRQ_WARM_DONE   0
`define CPR_IRQ_STOP_EXIT   1
`define CPR_IRQ_SWITCHBACK  2
`define CPR_IRQ_W           3

// ----------------------------------------------------------------
// Encodings, reset values and timing
// ----------------------------------------------------------------
`define CPR_DIV_1           2'h0
`define CPR_DIV_SLOW        2'h3
`define CPR_D256_LAST       8'hFF
`define CPR_START_ADDR      16'h8000
`define CPR_WARMUP_OSC      65536
`define CPR_CLK_HZ          10000000
`define CPR_RST_HOLD_NS     1600
`define CPR_RST_HOLD_CYC    ((`CPR_RST_HOLD_NS * (`CPR_CLK_HZ / 1000000) + 999) / 1000)

`endif

/* hw/cpr_pkg.sv */
// Types shared by the clock, power and reset controller
package cpr_pkg;

    typedef enum logic [2:0] {
        CPR_SRC_RING,
        CPR_SRC_HF_XTAL,
        CPR_SRC_HF_EXT,
        CPR_SRC_LF_XTAL,
        CPR_SRC_LF_EXT
    } cpr_src_e;

    typedef enum logic [2:0] {
        CPR_ST_POR,
        CPR_ST_WDT,
        CPR_ST_EXT,
        CPR_ST_RUN,
        CPR_ST_STOP,
        CPR_ST_WARM_WAIT
    } cpr_state_e;

    typedef struct packed {
        cpr_state_e  state;
        logic [4:0]  hold_cnt;
        logic [1:0]  div_sel;
        logic        pm_en;
        logic        stop_req;
        logic        sb_en;
        logic        wait_warm;
        cpr_src_e    src_sel;
        cpr_src_e    act_src;
        logic [1:0]  act_div;
        logic        act_d256;
        logic [7:0]  tick_cnt;
        logic        xtal_ready;
        logic [19:0] warm_cnt;
        logic        por_flag;
        logic [2:0]  irq_stat;
        logic [2:0]  irq_mask;
        logic [15:0] rdata;
        logic        sys_clk_en;
        logic        cpu_reset;
        logic        hf_osc_en;
        logic        pin_drive;
        logic        irq;
    } cpr_state_s;

endpackage

/* testbench/cpr_ctrl_monitor.sv */
// Port checks for the clock, power and reset controller
`timescale 1ns/1ps
module cpr_ctrl_monitor
    import cpr_pkg::*;
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Clocking
    input wire logic [4:0]  osc_tick,
    input wire logic        hf_osc_enable,
    input wire logic        sys_clk_en,
    input wire cpr_src_e    active_source,
    // Reset pin and CPU
    input wire logic        reset_pin_in,
    input wire logic        reset_pin_out,
    input wire logic        reset_pin_oe_n,
    input wire logic        cpu_reset,
    input wire logic [15:0] cpu_start_addr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_pin_held;
        !reset_pin_oe_n [*8] ##1 !reset_pin_oe_n [*8];
    endsequence
    chk_por_pin: assert property ($rose(rst_n) |-> s_pin_held ##1 reset_pin_oe_n)
        else $error("pin not held then freed");
    chk_pin_drive: assert property (!reset_pin_oe_n |-> !reset_pin_out && cpu_reset)
        else $error("pin drive bad");
    chk_start_addr: assert property (cpu_start_addr == 16'h8000)
        else $error("start address");
    chk_reset_halts: assert property (cpu_reset |-> !sys_clk_en && hf_osc_enable)
        else $error("reset state clocks");
    chk_stop_halts: assert property (!hf_osc_enable |-> !sys_clk_en)
        else $error("clock while stopped");
    chk_tick_cause: assert property (sys_clk_en && $stable(active_source) |->
        $past(osc_tick[active_source])) else $error("pulse without tick");
    chk_ext_hold: assert property (!reset_pin_in |-> ##[1:2] cpu_reset)
        else $error("pin low not in reset");
    chk_free_run: assert property ($fell(cpu_reset) |->
        $past(reset_pin_in && reset_pin_oe_n)) else $error("left reset early");
endmodule

/* testbench/cpr_osc_model.sv */
// Oscillators and pulled-up reset pin around the controller
`timescale 1ns/1ps
module cpr_osc_model (
    // Clock
    input wire logic  mclk,
    // Controller side
    input wire logic  hf_osc_enable,
    input wire logic  reset_pin_out,
    input wire logic  reset_pin_oe_n,
    // Bench side
    input wire logic  ext_rst_n,
    output logic [4:0] osc_tick = 5'h00,
    output logic      reset_pin_in
);
    logic [7:0] cnt = 8'h00;
    // Crystal ticks only while its oscillator is powered
    always @(posedge mclk) begin
        cnt <= cnt + 8'h01;
        osc_tick[0] <= cnt[0];
        osc_tick[1] <= hf_osc_enable && (cnt % 8'h03 == 8'h00);
        osc_tick[2] <= cnt % 8'h03 == 8'h01;
        osc_tick[3] <= cnt[3:0] == 4'h0;
        osc_tick[4] <= cnt[3:0] == 4'h8;
    end
    assign reset_pin_in = ext_rst_n && (reset_pin_oe_n || reset_pin_out);
endmodule

/* testbench/tb_cpr_ctrl.sv */
// Bench for the clock, power and reset controller
`timescale 1ns/1ps
`include "cpr_map.svh"
module tb_cpr_ctrl;
    import cpr_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        ext_int_wake = 1'b0;
    logic        rtc_alarm_wake = 1'b0;
    logic        switchback_irq = 1'b0;
    logic        watchdog_reset_req = 1'b0;
    logic        ext_rst_n = 1'b1;
    logic [15:0] reg_rdata, cpu_start_addr, d;
    logic [4:0]  osc_tick;
    logic        hf_osc_enable, reset_pin_in, reset_pin_out, reset_pin_oe_n;
    logic        sys_clk_en, cpu_reset, irq;
    cpr_src_e    active_source;
    int          n_fail = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          g, k;
    cpr_ctrl #(.WARMUP_CYCLES(8)) cpr_ctrl_inst (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .osc_tick, .hf_osc_enable, .ext_int_wake, .rtc_alarm_wake,
        .switchback_irq, .watchdog_reset_req, .reset_pin_in, .reset_pin_out, .reset_pin_oe_n,
        .sys_clk_en, .cpu_reset, .cpu_start_addr, .active_source, .irq);
    cpr_osc_model cpr_osc_model_inst (.mclk, .hf_osc_enable, .reset_pin_out, .reset_pin_oe_n,
        .ext_rst_n, .osc_tick, .reset_pin_in);
    initial begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) cyc++;
    // ----------------------------------------------------------------
    // Bus and helper tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask
    // Period between two system clock pulses, bounded wait
    task automatic gap();
        int t0;
        t0 = 0;
        for (int p = 0; p < 2; p++) begin
            t0 = cyc;
            k = 0;
            do begin
                @(negedge mclk);
                k++;
            end while (sys_clk_en !== 1'b1 && k < 2000);
        end
        g = cyc - t0;
    endtask
    task automatic wait_free();
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (cpu_reset !== 1'b0 && k < 300);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        check(cpu_reset, 1, "cpu_reset");
        check(hf_osc_enable, 1, "hf_osc_enable");
        check(reset_pin_oe_n, 0, "pin drive");
        @(posedge mclk);
        rst_n <= 1'b1;
        wait_free();
        check(cpu_reset, 0, "released");
        rd(`CPR_ADDR_WDCTRL);
        check(d[7], 1, "por flag");
        rd(`CPR_ADDR_CTRL);
        check(d, 0, "ctrl reset");
        check(active_source, CPR_SRC_RING, "source");
        check(cpu_start_addr, `CPR_START_ADDR, "start addr");
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(`CPR_ADDR_CTRL, 16'(i));
            gap();
            gap();
            check(16'(g), 16'(2 << i), "div gap");
        end
        wr(`CPR_ADDR_CTRL, 16'h0004);
        gap();
        gap();
        check(16'(g), 16'd512, "d256 gap");
        wr(`CPR_ADDR_CTRL, 16'h0007);
        gap();
        gap();
        check(active_source, CPR_SRC_LF_XTAL, "32k source");
        rd(`CPR_ADDR_STATUS);
        check(d[6:0], 7'h4B, "32k status");
        wr(`CPR_ADDR_CTRL, 16'h0107);
        gap();
        gap();
        check(active_source, CPR_SRC_LF_EXT, "32k ext source");
        wr(`CPR_ADDR_CTRL, 16'h0014);
        gap();
        @(posedge mclk);
        switchback_irq <= 1'b1;
        @(posedge mclk);
        switchback_irq <= 1'b0;
        rd(`CPR_ADDR_CTRL);
        check(d[2], 0, "switchback");
        gap();
        gap();
        check(16'(g), 16'd2, "full speed");
        $display("test divide done");
        wr(`CPR_ADDR_CTRL, 16'h0060);
        gap();
        gap();
        check(active_source, CPR_SRC_HF_XTAL, "hf source");
        wr(`CPR_ADDR_CTRL, 16'h0080);
        gap();
        gap();
        check(active_source, CPR_SRC_HF_EXT, "hf ext source");
        wr(`CPR_ADDR_CTRL, 16'h0068);
        @(negedge mclk);
        check(hf_osc_enable, 0, "osc stopped");
        g = 0;
        repeat (40) begin
            @(negedge mclk);
            g += int'(sys_clk_en === 1'b1);
        end
        check(16'(g), 0, "stopped pulses");
        @(posedge mclk);
        ext_int_wake <= 1'b1;
        @(posedge mclk);
        ext_int_wake <= 1'b0;
        k = 0;
        g = 0;
        while (sys_clk_en !== 1'b1 && k < 400) begin
            @(negedge mclk);
            k++;
            g += int'(osc_tick[1] === 1'b1);
        end
        check(g >= 8, 1, "warm-up ticks");
        check(sys_clk_en, 1, "run after warm-up");
        wr(`CPR_ADDR_IRQ_MASK, 16'h0002);
        rd(`CPR_ADDR_IRQ_STAT);
        check(d[1], 1, "stop exit flag");
        check(d[2:0], 3'h7, "event flags");
        check(irq, 1, "irq set");
        wr(`CPR_ADDR_IRQ_STAT, 16'h0007);
        repeat (2) @(negedge mclk);
        check(irq, 0, "irq cleared");
        wr(`CPR_ADDR_CTRL, 16'h0048);
        @(posedge mclk);
        rtc_alarm_wake <= 1'b1;
        @(posedge mclk);
        rtc_alarm_wake <= 1'b0;
        repeat (3) @(negedge mclk);
        check(active_source, CPR_SRC_RING, "ring in warm-up");
        k = 0;
        while (active_source !== CPR_SRC_HF_XTAL && k < 300) begin
            @(negedge mclk);
            k++;
        end
        check(active_source, CPR_SRC_HF_XTAL, "crystal back");
        $display("test stop done");
        wr(`CPR_ADDR_WDCTRL, 16'h0000);
        @(posedge mclk);
        watchdog_reset_req <= 1'b1;
        @(posedge mclk);
        watchdog_reset_req <= 1'b0;
        repeat (3) @(negedge mclk);
        check(reset_pin_oe_n, 0, "wdt pin");
        wait_free();
        check(active_source, CPR_SRC_RING, "wdt source");
        rd(`CPR_ADDR_WDCTRL);
        check(d[7], 0, "no por flag");
        rd(`CPR_ADDR_CTRL);
        check(d[3:0], 0, "ctrl cleared");
        @(posedge mclk);
        ext_rst_n <= 1'b0;
        repeat (30) @(negedge mclk);
        check(cpu_reset, 1, "ext reset");
        check(reset_pin_oe_n, 1, "pin not driven");
        @(posedge mclk);
        ext_rst_n <= 1'b1;
        wait_free();
        check(cpu_reset, 0, "ext released");
        rd(4'hF);
        check(d, 0, "unmapped");
        $display("test resets done");
        close_out();
    end
    initial begin
        repeat (30000) @(posedge mclk);
        n_fail++;
        close_out();
    end
endmodule
bind cpr_ctrl cpr_ctrl_monitor cpr_ctrl_monitor_inst (.mclk, .rst_n, .osc_tick, .hf_osc_enable,
    .sys_clk_en, .active_source, .reset_pin_in, .reset_pin_out, .reset_pin_oe_n, .cpu_reset,
    .cpu_start_addr);
